// [dv/id_host_model.sv]
// Host model: issues one-cycle read and write strobes on the register port.
// Assumes one calling process and the device's no-wait strobe protocol.
`timescale 1ns/1ns
`default_nettype none

module id_host_model (
  // Clock.
  input  wire logic                 clock,
  // Request toward the device.
  output var  id_mem_pkg::reg_req_t bus
);
  import id_mem_pkg::*;

  initial bus = '0;

  // One request for one cycle; released address and data show the inverse, not the last value, and both strobes drop.
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge clock);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : xfer
endmodule : id_host_model
`default_nettype wire

// [dv/module_id_upper_memory_tb_top.sv]
// Testbench: sweeps both pages after each capture and compares every byte read.
// Assumes the design and the host model files are compiled first.
`timescale 1ns/1ns
`default_nettype none

module module_id_upper_memory_tb_top;
  import id_mem_pkg::*;

  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  reg_req_t    bus;
  logic [7:0]  rdata;
  id_content_t content;
  logic        id_ready;
  int          n_errors   = 0;
  int          num_checks = 0;
  int          seed       = 32'ha6b7b561;
  int          k;
  logic [7:0]  expq[$];
  logic [7:0]  p0[64];
  logic [7:0]  p1[128];
  logic [7:0]  s;
  logic        rd_seen    = 1'b0;
  logic        bad_date   = 1'b0;
  logic        pad;
  logic [5:0]  len_exp;

  // Clock of 50 ns period.
  always #25 clock = ~clock;

  id_host_model id_host_model_inst (.clock(clock), .bus(bus));

  module_id_upper_memory module_id_upper_memory_inst (
    .clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .content(content), .id_ready(id_ready));

  // ----------------------------------------------------------------
  // Checking.
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: read 0x%h, expected 0x%h", $time, got, exp);
    end
  endtask : check_byte

  // Read data stands only in the cycle after the strobe, else zero.
  always @(posedge clock) begin
    rd_seen <= bus.rd;
    if (rd_seen) check_byte(rdata, expq.pop_front());
    else if (!rst) check_byte(rdata, 8'h00);
  end

  // ----------------------------------------------------------------
  // Stimulus and expected image.
  // ----------------------------------------------------------------
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    id_host_model_inst.xfer(a, 8'h00, 1'b0);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    id_host_model_inst.xfer(a, d, 1'b1);
  endtask : wr

  task automatic wait_ready();
    int i;
    @(posedge clock);
    for (i = 0; i < 400 && id_ready !== 1'b1; i++) @(posedge clock);
    if (id_ready !== 1'b1) begin
      n_errors++;
      $display("Error %0t: ready never rose", $time);
    end
  endtask : wait_ready

  // Builds the bytes the host should see from the content image.
  task automatic build();
    p0 = '{default: 8'h00};
    p1 = '{default: 8'h00};
    p0[1] = content.opt_193 & 8'h01;
    p0[2] = content.opt_194 & 8'h0F;
    p0[3] = (content.opt_195 & 8'hBE) | {1'b0, content.app_table_sel, 6'h00};
    // Only the unused tail of a non-empty serial turns into spaces; inner zero bytes stay.
    pad = (content.serial != 0);
    for (k = 15; k >= 0; k--) begin
      if (content.serial[k] != 0) pad = 1'b0;
      p0[4+k] = pad ? 8'h20 : content.serial[k];
    end
    for (k = 0; k < 8; k++) p0[20+k] = (k > 5 && content.date[k] == 0) ? 8'h20 : content.date[k];
    if (bad_date) for (k = 0; k < 6; k++) p0[20+k] = DEFAULT_DATE[8*k +: 8];
    p0[28] = {4'h0, content.rx_avg_power, 3'b000};
    p0[29] = {4'h0, content.ext_rate_sel & ~content.app_table_sel, content.app_table_sel, 2'b00};
    s = 8'h00;
    for (k = 0; k < 31; k++) s += p0[k];
    p0[31] = s;
    for (k = 0; k < 32; k++) p0[32+k] = content.maker[k];
    if (content.app_table_sel) begin
      // A length code of 63 is out of range and reads back as the largest legal code.
      len_exp = (content.app_len == 6'h3F) ? 6'h3E : content.app_len;
      p1[1] = {2'b00, len_exp};
      for (k = 0; k <= int'(len_exp); k++) {p1[2+2*k], p1[3+2*k]} = content.app_entries[k];
      s = 8'h00;
      for (k = 1; k < 128; k++) s += p1[k];
      p1[0] = s;
    end
  endtask : build

  task automatic sweep0();
    for (k = 0; k < 64; k++) rd(P0_BASE + 8'(k), p0[k]);
    rd(UPPER_BASE, 8'h00);
  endtask : sweep0

  task automatic sweep1();
    for (k = 0; k < 128; k++) rd(UPPER_BASE + 8'(k), p1[k]);
  endtask : sweep1

  // Main sequence.
  initial begin
    content = '0;
    for (k = 0; k < 16; k++) content.serial[k] = (k < 12) ? 8'h41 + 8'($random(seed) & 15) : 8'h00;
    content.date = 64'h0000_3531_3330_3432;
    content.opt_193 = 8'hFF;
    content.opt_194 = 8'hFF;
    content.opt_195 = 8'hBF;
    content.rx_avg_power = 1'b1;
    content.ext_rate_sel = 1'b1;
    content.app_table_sel = 1'b1;
    content.app_len = 6'h02;
    for (k = 0; k < 32; k++) content.maker[k] = 8'($random(seed));
    for (k = 0; k < 63; k++) content.app_entries[k] = 16'($random(seed));
    build();
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    wait_ready();
    rd(STATUS_ADDR, 8'h05);
    sweep0();
    rd(8'h10, 8'h00);
    wr(MAKER_ADDR + 8'h03, ~p0[35]);
    rd(MAKER_ADDR + 8'h03, p0[35]);
    rd(STATUS_ADDR, 8'h0D);
    wr(STATUS_ADDR, 8'h08);
    rd(STATUS_ADDR, 8'h05);
    wr(PAGE_SEL_ADDR, PAGE_APP);
    rd(PAGE_SEL_ADDR, PAGE_APP);
    sweep1();
    // Second capture: no serial and no table page.
    @(posedge clock);
    content.serial <= '0;
    content.app_table_sel <= 1'b0;
    @(negedge clock);
    build();
    wr(RELOAD_ADDR, 8'h01);
    wait_ready();
    rd(STATUS_ADDR, 8'h03);
    sweep1();
    wr(PAGE_SEL_ADDR, PAGE_ID);
    sweep0();
    // Third capture: bad month, a gap inside the serial, longest table, amplitude monitoring.
    @(posedge clock);
    content.serial        <= 128'h0000_0000_0000_4A49_0048_4746_4544_4342;
    content.date          <= 64'h0000_3531_3331_3432;
    content.rx_avg_power  <= 1'b0;
    content.ext_rate_sel  <= 1'b0;
    content.app_table_sel <= 1'b1;
    content.app_len       <= 6'h3F;
    bad_date              <= 1'b1;
    @(negedge clock);
    build();
    wr(RELOAD_ADDR, 8'h01);
    wait_ready();
    rd(STATUS_ADDR, 8'h05);
    sweep0();
    wr(PAGE_SEL_ADDR, PAGE_APP);
    sweep1();
    repeat (3) @(posedge clock);
    summarize();
  end

  // Watchdog at 20000 cycles, well beyond the expected 1600 or so.
  initial begin
    #1_000_000;
    n_errors++;
    $display("Error %0t: watchdog expired", $time);
    summarize();
  end
endmodule : module_id_upper_memory_tb_top
`default_nettype wire

// [logic/module_id_upper_memory.sv]
// Read-only upper identity memory of a pluggable four-lane module: page 00
// bytes 192-255 and the application table page 01, with hardware check codes.
// Assumes content arrives as a steady input image and the register port
// follows the one-cycle strobe protocol of the local management bus.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module module_id_upper_memory (
  // Clock and reset.
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Register port.
  input  wire id_mem_pkg::reg_req_t   bus,
  output logic                  [7:0] rdata,
  // Identity content.
  input  wire id_mem_pkg::id_content_t content,
  // Status.
  output logic                        id_ready
);
  import id_mem_pkg::*;

  // ----------------------------------------------------------------
  // Storage and indices.
  // ----------------------------------------------------------------
  localparam int OPT_I   = OPT_ADDR - P0_BASE;
  localparam int SN_I    = SERIAL_ADDR - P0_BASE;
  localparam int DATE_I  = DATE_ADDR - P0_BASE;
  localparam int MON_I   = MON_KIND_ADDR - P0_BASE;
  localparam int CAP_I   = EXTRA_CAP_ADDR - P0_BASE;
  localparam int CSUM_I  = EXT_CSUM_ADDR - P0_BASE;
  localparam int MAKER_I = MAKER_ADDR - P0_BASE;
  localparam int LEN_I   = APP_LEN_ADDR - UPPER_BASE;
  localparam int ENT_I   = APP_ENTRY_ADDR - UPPER_BASE;

  logic [P0_DEPTH-1:0][7:0] p0_mem;
  logic [P1_DEPTH-1:0][7:0] p1_mem;
  logic [P0_DEPTH-1:0][7:0] p0_image;
  logic [P1_DEPTH-1:0][7:0] p1_image;
  logic [SN_LEN-1:0][7:0]   sn_padded;
  logic [DATE_LEN-1:0][7:0] date_fixed;
  logic [5:0]               app_len;
  id_state_t                state_reg;
  id_state_t                state_next;
  logic [1:0]               sums_done_reg;
  logic [7:0]               page_reg;
  logic                     refused_reg;
  logic [7:0]               rd_value;
  logic [7:0]               status_byte;
  logic                     sn_absent;
  logic                     table_present;
  logic                     reload_hit;
  logic                     ctrl_hit;
  logic [7:0]               ext_idx;
  logic [7:0]               ext_sum;
  logic                     ext_done;
  logic [7:0]               app_idx;
  logic [7:0]               app_sum;
  logic                     app_done;
  logic                     start;

  // ----------------------------------------------------------------
  // Content shaping.
  // ----------------------------------------------------------------

  // Checks that a two-digit ASCII pair is a number from one to max.
  function automatic logic pair_ok(input logic [7:0] hi, input logic [7:0] lo,
                                   input logic [7:0] max);
    logic [7:0] val;
    val = 8'h00;
    if (hi < ASCII_ZERO || hi > ASCII_NINE || lo < ASCII_ZERO || lo > ASCII_NINE) begin
      return 1'b0;
    end
    val = 8'((hi - ASCII_ZERO) * 8'h0A + (lo - ASCII_ZERO));
    return (val != 8'h00) && (val <= max);
  endfunction : pair_ok

  // Trailing unused serial bytes become spaces unless the whole field is zero.
  always_comb begin
    logic tail;
    tail      = 1'b1;
    sn_padded = content.serial;
    for (int i = SN_LEN - 1; i >= 0; i--) begin
      if (content.serial[i] != 8'h00) begin
        tail = 1'b0;
      end
      if (tail && (content.serial != '0)) begin
        sn_padded[i] = ASCII_SPACE;
      end
    end
  end

  // A malformed date is replaced so the field always holds a legal date.
  always_comb begin
    date_fixed = content.date;
    if (!(pair_ok(content.date[0], content.date[1], 8'h63) || content.date[1:0] == 16'h3030)
        || !pair_ok(content.date[2], content.date[3], MONTH_MAX)
        || !pair_ok(content.date[4], content.date[5], DAY_MAX)) begin
      date_fixed[5:0] = DEFAULT_DATE[47:0];
    end
    for (int i = 6; i < DATE_LEN; i++) begin
      if (date_fixed[i] == 8'h00) begin
        date_fixed[i] = ASCII_SPACE;
      end
    end
  end

  // The length field is held to its legal range.
  assign app_len = (content.app_len > APP_LEN_MAX) ? APP_LEN_MAX : content.app_len;

  // Builds the page 00 image; the check code byte is filled in later.
  always_comb begin
    p0_image = '0;
    p0_image[OPT_I + 1] = {7'h00, content.opt_193[0]};
    p0_image[OPT_I + 2] = {4'h0, content.opt_194[3:0]};
    p0_image[OPT_I + 3] = {content.opt_195[7], content.app_table_sel,
                           content.opt_195[5:1], 1'b0};
    for (int i = 0; i < SN_LEN; i++) begin
      p0_image[SN_I + i] = sn_padded[i];
    end
    for (int i = 0; i < DATE_LEN; i++) begin
      p0_image[DATE_I + i] = date_fixed[i];
    end
    // Monitor readings are reported calibrated; this byte only names the kind.
    p0_image[MON_I][MON_AVG_BIT] = content.rx_avg_power;
    // The table mechanism wins when both rate schemes are requested.
    p0_image[CAP_I][CAP_EXT_BIT] = content.ext_rate_sel && !content.app_table_sel;
    p0_image[CAP_I][CAP_APP_BIT] = content.app_table_sel;
    for (int i = 0; i < MAKER_LEN; i++) begin
      p0_image[MAKER_I + i] = content.maker[i];
    end
  end

  // Builds the table page; entries past the last one read zero.
  always_comb begin
    p1_image = '0;
    if (content.app_table_sel) begin
      p1_image[LEN_I] = {2'b00, app_len};
      for (int i = 0; i < APP_ENTRIES; i++) begin
        if (6'(i) <= app_len) begin
          p1_image[ENT_I + 2*i]     = content.app_entries[i][15:8];
          p1_image[ENT_I + 2*i + 1] = content.app_entries[i][7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Load sequencing.
  // ----------------------------------------------------------------
  assign start      = (state_reg == ST_CAPTURE);
  assign ctrl_hit   = (bus.addr == RELOAD_ADDR) || (bus.addr == STATUS_ADDR)
                      || (bus.addr == PAGE_SEL_ADDR);
  assign reload_hit = bus.wr && (bus.addr == RELOAD_ADDR) && bus.wdata[0];

  // Capture, then sum both pages, then serve; a reload starts over.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_CAPTURE: state_next = ST_SUMMING;
      ST_SUMMING: if (sums_done_reg == 2'b11) state_next = ST_READY;
      ST_READY:   state_next = ST_READY;
      default:    state_next = ST_CAPTURE;
    endcase
    if (reload_hit) begin
      state_next = ST_CAPTURE;
    end
  end

  // State register and the ready output that mirrors it.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_CAPTURE;
      id_ready  <= 1'b0;
    end else begin
      state_reg <= state_next;
      id_ready  <= (state_next == ST_READY);
    end
  end

  // Remembers which check codes have been written since the last capture.
  always_ff @(posedge clock) begin
    if (rst || start) begin
      sums_done_reg <= 2'b00;
    end else begin
      sums_done_reg <= sums_done_reg | {app_done, ext_done};
    end
  end

  // ----------------------------------------------------------------
  // Check code engines.
  // ----------------------------------------------------------------
  sum_walker #(
    .FIRST (P0_BASE),
    .LAST  (EXT_SUM_LAST)
  ) ext_walker (
    .clock   (clock),
    .rst     (rst),
    .start   (start),
    .byte_in (p0_mem[6'(ext_idx - P0_BASE)]),
    .index   (ext_idx),
    .sum     (ext_sum),
    .busy    (),
    .done    (ext_done)
  );

  sum_walker #(
    .FIRST (APP_LEN_ADDR),
    .LAST  (LAST_ADDR)
  ) app_walker (
    .clock   (clock),
    .rst     (rst),
    .start   (start),
    .byte_in (p1_mem[7'(app_idx - UPPER_BASE)]),
    .index   (app_idx),
    .sum     (app_sum),
    .busy    (),
    .done    (app_done)
  );

  // Page 00 storage; software never writes it.
  always_ff @(posedge clock) begin
    if (rst) begin
      p0_mem <= '0;
    end else if (start) begin
      p0_mem <= p0_image;
    end else if (ext_done) begin
      p0_mem[CSUM_I] <= ext_sum;
    end
  end

  // Table page storage; software never writes it.
  always_ff @(posedge clock) begin
    if (rst) begin
      p1_mem <= '0;
    end else if (start) begin
      p1_mem <= p1_image;
    end else if (app_done) begin
      p1_mem[0] <= app_sum;
    end
  end

  // ----------------------------------------------------------------
  // Register port.
  // ----------------------------------------------------------------
  assign sn_absent     = (p0_mem[SN_I +: SN_LEN] == '0);
  assign table_present = p0_mem[CAP_I][CAP_APP_BIT];
  assign status_byte   = {4'h0, refused_reg, table_present, sn_absent, id_ready};

  // Page select is the only byte that stores written data; a status write can only clear its bit 3.
  always_ff @(posedge clock) begin
    if (rst) begin
      page_reg <= PAGE_SEL_RESET;
    end else if (bus.wr && bus.addr == PAGE_SEL_ADDR) begin
      page_reg <= bus.wdata;
    end
  end

  // Sticky flag for refused writes; a new refusal beats a clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      refused_reg <= 1'b0;
    end else if (bus.wr && !ctrl_hit) begin
      refused_reg <= 1'b1;
    end else if (bus.wr && bus.addr == STATUS_ADDR && bus.wdata[3]) begin
      refused_reg <= 1'b0;
    end
  end

  // Read decode; unmapped bytes and a missing table page read zero.
  always_comb begin
    rd_value = 8'h00;
    if (!bus.addr[7]) begin
      if (bus.addr == PAGE_SEL_ADDR) begin
        rd_value = page_reg;
      end else if (bus.addr == STATUS_ADDR) begin
        rd_value = status_byte;
      end
    end else if (page_reg == PAGE_ID) begin
      if (bus.addr >= P0_BASE) begin
        rd_value = p0_mem[6'(bus.addr - P0_BASE)];
      end
    end else if (page_reg == PAGE_APP && table_present) begin
      rd_value = p1_mem[7'(bus.addr - UPPER_BASE)];
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= bus.rd ? rd_value : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  logic [7:0] ext_check;
  logic [7:0] app_check;

  // Independent sums of the stored bytes for the check code assertions.
  always_comb begin
    ext_check = 8'h00;
    app_check = 8'h00;
    for (int i = 0; i < CSUM_I; i++) begin
      ext_check = 8'(ext_check + p0_mem[i]);
    end
    for (int i = 1; i < P1_DEPTH; i++) begin
      app_check = 8'(app_check + p1_mem[i]);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_serial_padded: assert property (
    bus.rd && bus.addr == SERIAL_LAST && page_reg == PAGE_ID && !sn_absent
    |=> rdata != 8'h00) else $error("serial field has a zero byte");

  a_date_digits: assert property (
    bus.rd && bus.addr >= DATE_ADDR && bus.addr < LOT_ADDR && page_reg == PAGE_ID
    |=> rdata >= ASCII_ZERO && rdata <= ASCII_NINE) else $error("date byte not a digit");

  a_lot_blank: assert property (
    bus.rd && bus.addr >= LOT_ADDR && bus.addr < MON_KIND_ADDR && page_reg == PAGE_ID
    |=> rdata != 8'h00) else $error("lot code byte is zero");

  a_monitor_reserved: assert property (
    bus.rd && bus.addr == MON_KIND_ADDR && page_reg == PAGE_ID && state_reg == ST_READY
    |=> rdata[7:4] == 4'h0 && rdata[2:0] == 3'h0
        && rdata[MON_AVG_BIT] == $past(content.rx_avg_power)) else $error("diagnostic type wrong");

  a_rate_exclusive: assert property (
    !(p0_mem[CAP_I][CAP_EXT_BIT] && p0_mem[CAP_I][CAP_APP_BIT])) else $error("both rate bits set");

  a_table_absent: assert property (
    bus.rd && bus.addr[7] && page_reg == PAGE_APP && !table_present
    |=> rdata == 8'h00) else $error("missing table page reads nonzero");

  a_table_flag: assert property (
    state_reg == ST_READY |-> p0_mem[OPT_I + 3][OPT_APP_BIT] == table_present)
    else $error("option bit 6 disagrees with table");

  a_ext_sum: assert property (
    state_reg == ST_READY |-> p0_mem[CSUM_I] == ext_check) else $error("extended check code wrong");

  a_app_sum: assert property (
    state_reg == ST_READY |-> p1_mem[0] == app_check) else $error("table check code wrong");

  a_length_range: assert property (
    p1_mem[LEN_I][7:6] == 2'b00 && p1_mem[LEN_I][5:0] <= APP_LEN_MAX) else $error("table length out of range");

  a_maker_readonly: assert property (
    bus.wr && bus.addr >= MAKER_ADDR && state_reg == ST_READY
    |=> $stable(p0_mem[MAKER_I +: MAKER_LEN]) ##0 refused_reg) else $error("maker area took a write");

  a_ready_in_time: assert property (
    $rose(start) |-> ##[130:131] id_ready) else $error("check codes late");

endmodule : module_id_upper_memory
`default_nettype wire

// [logic/sum_walker.sv]
// Walks a byte range one address a cycle and adds the bytes modulo 256.
// Assumes the caller returns the byte at index in the same cycle, with no delay.
`timescale 1ns/1ns
`default_nettype none

module sum_walker #(
  parameter logic [7:0] FIRST = 8'hC0,
  parameter logic [7:0] LAST  = 8'hDE
) (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst,
  // Control.
  input  wire logic       start,
  // Byte fetch.
  input  wire logic [7:0] byte_in,
  output logic      [7:0] index,
  // Result.
  output logic      [7:0] sum,
  output logic            busy,
  output logic            done
);

  // ----------------------------------------------------------------
  // Walk and accumulate.
  // ----------------------------------------------------------------

  // A start restarts the walk from the first byte with a cleared sum.
  always_ff @(posedge clock) begin
    if (rst) begin
      index <= FIRST;
      sum   <= 8'h00;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (start) begin
      index <= FIRST;
      sum   <= 8'h00;
      busy  <= 1'b1;
      done  <= 1'b0;
    end else begin
      done <= busy && (index == LAST);
      if (busy) begin
        sum <= sum + byte_in;  // Carries out of bit 7 are dropped.
        if (index == LAST) begin
          busy <= 1'b0;
        end else begin
          index <= index + 8'h01;
        end
      end
    end
  end

endmodule : sum_walker
`default_nettype wire

// [shared/id_mem_pkg.sv]
// Constants, types and the register map of the module identity upper memory.
// Assumes a single 20 MHz clock and a byte-wide plain register port.
//
// Behaviour
// - Serial number is 16 ASCII bytes, left aligned, trailing gaps become 20h.
// - An all-zero serial field means unspecified; the reader treats it as absent.
// - Date always holds eight ASCII bytes: year from 2000, month 01-12, day 01-31.
// - The last two date bytes hold a maker lot code and may be blank.
// - Diagnostic type bit 3 is 1 for average power, 0 for modulation amplitude.
// - Monitor values are calibrated inside the device and reported in defined units.
// - Capability bit 3 is 0 without rate selection, 1 with extended rate selection.
// - Capability bit 2 is 1 with an application table; 0 means no table page.
// - Both rate selection declaration bits are never 1 together.
// - Byte 223 is the low byte of the sum of bytes 192 to 222.
// - The maker area, bytes 224-255, reads freely and refuses writes.
// - Table page byte 128 is the low byte of the sum of bytes 129 to 255.
// - Table length, bits 5-0 of byte 129, is entries minus one, 0 to 62.
// - Entries are byte pairs from 130; the last sits at 130+2*length.
// - Option byte 195 bit 6 is 1 exactly when the table page is provided.

package id_mem_pkg;

  // ----------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------
  localparam logic [7:0] RELOAD_ADDR     = 8'h7D;
  localparam logic [7:0] STATUS_ADDR     = 8'h7E;
  localparam logic [7:0] PAGE_SEL_ADDR   = 8'h7F;
  localparam logic [7:0] UPPER_BASE      = 8'h80;
  localparam logic [7:0] P0_BASE         = 8'hC0;
  localparam logic [7:0] OPT_ADDR        = 8'hC0;
  localparam logic [7:0] SERIAL_ADDR     = 8'hC4;
  localparam logic [7:0] SERIAL_LAST     = 8'hD3;
  localparam logic [7:0] DATE_ADDR       = 8'hD4;
  localparam logic [7:0] LOT_ADDR        = 8'hDA;
  localparam logic [7:0] MON_KIND_ADDR   = 8'hDC;
  localparam logic [7:0] EXTRA_CAP_ADDR  = 8'hDD;
  localparam logic [7:0] EXT_SUM_LAST    = 8'hDE;
  localparam logic [7:0] EXT_CSUM_ADDR   = 8'hDF;
  localparam logic [7:0] MAKER_ADDR      = 8'hE0;
  localparam logic [7:0] APP_CSUM_ADDR   = 8'h80;
  localparam logic [7:0] APP_LEN_ADDR    = 8'h81;
  localparam logic [7:0] APP_ENTRY_ADDR  = 8'h82;
  localparam logic [7:0] LAST_ADDR       = 8'hFF;
  localparam logic [7:0] PAGE_ID         = 8'h00;
  localparam logic [7:0] PAGE_APP        = 8'h01;

  // ----------------------------------------------------------------
  // Field positions, sizes and fixed values.
  // ----------------------------------------------------------------
  localparam int unsigned MON_AVG_BIT    = 3;
  localparam int unsigned CAP_EXT_BIT    = 3;
  localparam int unsigned CAP_APP_BIT    = 2;
  localparam int unsigned OPT_APP_BIT    = 6;
  localparam int unsigned SN_LEN         = 16;
  localparam int unsigned DATE_LEN       = 8;
  localparam int unsigned MAKER_LEN      = 32;
  localparam int unsigned APP_ENTRIES    = 63;
  localparam int unsigned P0_DEPTH       = 64;
  localparam int unsigned P1_DEPTH       = 128;
  localparam logic [5:0]  APP_LEN_MAX    = 6'h3E;
  localparam logic [7:0]  ASCII_SPACE    = 8'h20;
  localparam logic [7:0]  ASCII_ZERO     = 8'h30;
  localparam logic [7:0]  ASCII_NINE     = 8'h39;
  localparam logic [7:0]  MONTH_MAX      = 8'h0C;
  localparam logic [7:0]  DAY_MAX        = 8'h1F;
  localparam logic [7:0]  PAGE_SEL_RESET = 8'h00;
  // Fallback date "000101" with a blank lot code, byte 212 in the low byte.
  localparam logic [63:0] DEFAULT_DATE   = 64'h2020_3130_3130_3030;

  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b00,
    ST_SUMMING = 2'b01,
    ST_READY   = 2'b11
  } id_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Element 0 of each byte array is the lowest address of its field.
  typedef struct packed {
    logic [SN_LEN-1:0][7:0]       serial;
    logic [DATE_LEN-1:0][7:0]     date;
    logic [7:0]                   opt_193;
    logic [7:0]                   opt_194;
    logic [7:0]                   opt_195;
    logic                         rx_avg_power;
    logic                         ext_rate_sel;
    logic                         app_table_sel;
    logic [MAKER_LEN-1:0][7:0]    maker;
    logic [5:0]                   app_len;
    logic [APP_ENTRIES-1:0][15:0] app_entries;
  } id_content_t;

endpackage : id_mem_pkg
